// ---- hdl/pat_translate.sv ----
// paged virtual to physical translation with residency check and usage flags
// assumes core and memory handshakes and apb all run on clk_in
`timescale 1ns/10ps
`default_nettype none
module pat_translate (
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // core request side
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [pat_pkg::VA_W-1:0] req_addr_in,
    input wire logic [15:0] processor_status_word_in,
    output logic req_ready_out,
    output logic req_done_out,
    output logic req_abort_out,
    // memory side
    output logic mem_valid_out,
    output logic mem_write_out,
    output logic [pat_pkg::PA_W-1:0] mem_addr_out,
    input wire logic mem_ready_in,
    // interrupt to the core
    output logic irq_out
);
    localparam int IW = pat_pkg::IDX_W;
    localparam int DW = pat_pkg::FRAME_W + 1;

    ////////////////////////////////////////////////////////////////////////////
    // apb registers
    logic en_ff, nxt_en;
    logic stat_ff, nxt_stat;
    logic mask_ff, nxt_mask;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic irq_ff, nxt_irq;
    logic apb_wr, is_map, known;
    logic [IW-1:0] apb_idx;
    logic [DW-1:0] map_wdata, rda_data, rdb_data;
    logic [(1<<IW)-1:0] acc_vec, wr_vec;

    // translation state
    pat_pkg::pat_state_e st_ff, nxt_st;
    logic [pat_pkg::VA_W-1:0] va_ff, nxt_va;
    logic [pat_pkg::SPACE_W-1:0] sp_ff, nxt_sp;
    logic rw_ff, nxt_rw;
    logic rdy_ff, nxt_rdy;
    logic done_ff, nxt_done;
    logic abort_ff, nxt_abort;
    logic mv_ff, nxt_mv;
    logic mw_ff, nxt_mw;
    logic [pat_pkg::PA_W-1:0] ma_ff, nxt_ma;
    logic [31:0] fault_ff, nxt_fault;
    logic take, fault_ev, use_set;
    logic [IW-1:0] look_idx;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; one wait state so map reads come from the registered ram port
    always_comb
    begin
        is_map = paddr_in[11:7] == pat_pkg::MAP_SEL;
        apb_idx = paddr_in[6:2];
        known = is_map || paddr_in == pat_pkg::CTRL_OFS || paddr_in == pat_pkg::STATUS_OFS
            || paddr_in == pat_pkg::MASK_OFS || paddr_in == pat_pkg::FAULT_OFS;
        apb_wr = psel_in && penable_in && pready_ff && pwrite_in && known;
        map_wdata = {pwdata_in[pat_pkg::ENT_RES_BIT], pwdata_in[pat_pkg::FRAME_W-1:0]};
    end

    always_comb
    begin
        nxt_en = en_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        nxt_pready = psel_in && penable_in && !pready_ff;
        nxt_pslverr = psel_in && penable_in && !pready_ff && !known;
        nxt_prdata = prdata_ff;
        if (apb_wr && paddr_in == pat_pkg::CTRL_OFS)
        begin
            nxt_en = pwdata_in[pat_pkg::CTRL_EN_BIT];
        end
        if (apb_wr && paddr_in == pat_pkg::MASK_OFS)
        begin
            nxt_mask = pwdata_in[pat_pkg::STAT_NRES_BIT];
        end
        if (apb_wr && paddr_in == pat_pkg::STATUS_OFS && pwdata_in[pat_pkg::STAT_NRES_BIT])
        begin
            nxt_stat = 1'b0;
        end
        // a fault in the clearing cycle is kept
        if (fault_ev)
        begin
            nxt_stat = 1'b1;
        end
        if (psel_in && penable_in && !pready_ff && !pwrite_in)
        begin
            nxt_prdata = 32'h0000_0000;
            if (is_map)
            begin
                nxt_prdata[pat_pkg::FRAME_W-1:0] = rdb_data[pat_pkg::FRAME_W-1:0];
                nxt_prdata[pat_pkg::ENT_RES_BIT] = rdb_data[DW-1];
                nxt_prdata[pat_pkg::ENT_ACC_BIT] = acc_vec[apb_idx];
                nxt_prdata[pat_pkg::ENT_WR_BIT] = wr_vec[apb_idx];
            end
            else if (paddr_in == pat_pkg::CTRL_OFS)
            begin
                nxt_prdata[pat_pkg::CTRL_EN_BIT] = en_ff;
            end
            else if (paddr_in == pat_pkg::STATUS_OFS)
            begin
                nxt_prdata[pat_pkg::STAT_NRES_BIT] = stat_ff;
            end
            else if (paddr_in == pat_pkg::MASK_OFS)
            begin
                nxt_prdata[pat_pkg::STAT_NRES_BIT] = mask_ff;
            end
            else if (paddr_in == pat_pkg::FAULT_OFS)
            begin
                nxt_prdata = fault_ff;
            end
        end
        nxt_irq = nxt_stat && nxt_mask;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            en_ff <= pat_pkg::CTRL_EN_RST;
            stat_ff <= pat_pkg::STAT_RST;
            mask_ff <= pat_pkg::MASK_RST;
            prdata_ff <= pat_pkg::DATA_RST;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            en_ff <= nxt_en;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // page map and usage flags
    pat_map_ram #(
        .AW(IW),
        .DW(DW)
    ) u_map (
        .clk_in(clk_in),
        .wr_en_in(apb_wr && is_map),
        .wr_addr_in(apb_idx),
        .wr_data_in(map_wdata),
        .rda_addr_in(look_idx),
        .rda_data_out(rda_data),
        .rdb_addr_in(apb_idx),
        .rdb_data_out(rdb_data)
    );

    pat_usage #(
        .AW(IW)
    ) u_usage (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .set_in(use_set),
        .set_wr_in(rw_ff),
        .set_idx_in({sp_ff, va_ff[pat_pkg::VA_W-1:pat_pkg::OFF_W]}),
        .clr_in(apb_wr && is_map),
        .clr_idx_in(apb_idx),
        .acc_out(acc_vec),
        .wr_out(wr_vec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // translation sequence: accept, look up, then issue or abort
    always_comb
    begin
        take = st_ff == pat_pkg::PAT_IDLE && req_valid_in && rdy_ff;
        // map selected by the two top status word bits
        look_idx = {processor_status_word_in[pat_pkg::PSW_SPACE_HI:pat_pkg::PSW_SPACE_LO],
            req_addr_in[pat_pkg::VA_W-1:pat_pkg::OFF_W]};
        fault_ev = st_ff == pat_pkg::PAT_LOOK && en_ff && !rda_data[DW-1];
        use_set = st_ff == pat_pkg::PAT_LOOK && en_ff && rda_data[DW-1];
        nxt_st = st_ff;
        nxt_va = va_ff;
        nxt_sp = sp_ff;
        nxt_rw = rw_ff;
        nxt_done = 1'b0;
        nxt_abort = 1'b0;
        nxt_mv = mv_ff;
        nxt_mw = mw_ff;
        nxt_ma = ma_ff;
        nxt_fault = fault_ff;
        case (st_ff)
            pat_pkg::PAT_IDLE:
            begin
                if (take)
                begin
                    nxt_va = req_addr_in;
                    nxt_sp = look_idx[IW-1:pat_pkg::PAGE_W];
                    nxt_rw = req_write_in;
                    nxt_st = pat_pkg::PAT_LOOK;
                end
            end
            pat_pkg::PAT_LOOK:
            begin
                if (fault_ev)
                begin
                    // transfer never reaches memory
                    nxt_abort = 1'b1;
                    nxt_fault = 32'h0000_0000;
                    nxt_fault[pat_pkg::VA_W-1:0] = va_ff;
                    nxt_fault[pat_pkg::FLT_SPACE_LO+:pat_pkg::SPACE_W] = sp_ff;
                    nxt_fault[pat_pkg::FLT_WR_BIT] = rw_ff;
                    nxt_st = pat_pkg::PAT_IDLE;
                end
                else
                begin
                    nxt_mv = 1'b1;
                    nxt_mw = rw_ff;
                    if (en_ff)
                    begin
                        nxt_ma = {rda_data[pat_pkg::FRAME_W-1:0],
                            va_ff[pat_pkg::OFF_W-1:0]};
                    end
                    else
                    begin
                        // relocation off: identity map into the low 64 kbytes
                        nxt_ma = {{(pat_pkg::PA_W-pat_pkg::VA_W){1'b0}}, va_ff};
                    end
                    nxt_st = pat_pkg::PAT_ISSUE;
                end
            end
            pat_pkg::PAT_ISSUE:
            begin
                if (mem_ready_in)
                begin
                    nxt_mv = 1'b0;
                    nxt_mw = 1'b0;
                    nxt_done = 1'b1;
                    nxt_st = pat_pkg::PAT_IDLE;
                end
            end
            default:
            begin
                nxt_st = pat_pkg::PAT_IDLE;
                nxt_mv = 1'b0;
            end
        endcase
        nxt_rdy = nxt_st == pat_pkg::PAT_IDLE && !take;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_ff <= pat_pkg::PAT_IDLE;
            va_ff <= '0;
            sp_ff <= '0;
            rw_ff <= 1'b0;
            rdy_ff <= 1'b0;
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
            mv_ff <= 1'b0;
            mw_ff <= 1'b0;
            ma_ff <= '0;
            fault_ff <= pat_pkg::DATA_RST;
        end
        else
        begin
            st_ff <= nxt_st;
            va_ff <= nxt_va;
            sp_ff <= nxt_sp;
            rw_ff <= nxt_rw;
            rdy_ff <= nxt_rdy;
            done_ff <= nxt_done;
            abort_ff <= nxt_abort;
            mv_ff <= nxt_mv;
            mw_ff <= nxt_mw;
            ma_ff <= nxt_ma;
            fault_ff <= nxt_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        prdata_out = prdata_ff;
        pready_out = pready_ff;
        pslverr_out = pslverr_ff;
        req_ready_out = rdy_ff;
        req_done_out = done_ff;
        req_abort_out = abort_ff;
        mem_valid_out = mv_ff;
        mem_write_out = mw_ff;
        mem_addr_out = ma_ff;
        irq_out = irq_ff;
    end
endmodule
`default_nettype wire

// ---- hdl/pat_pkg.sv ----
// constants, register map and state types for the paged address translation unit
// assumes a 16-bit virtual bus from the core and an 18-bit physical bus to memory
package pat_pkg;
    localparam int VA_W = 16;
    localparam int PA_W = 18;
    localparam int OFF_W = 13;
    localparam int SPACE_W = 2;
    localparam int PAGE_W = VA_W - OFF_W;
    localparam int IDX_W = SPACE_W + PAGE_W;
    localparam int ENTRIES = 1 << IDX_W;
    localparam int FRAME_W = PA_W - OFF_W;
    localparam int PSW_SPACE_HI = 15;
    localparam int PSW_SPACE_LO = 14;

    // apb register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] MASK_OFS = 12'h008;
    localparam logic [11:0] FAULT_OFS = 12'h00c;
    localparam logic [11:0] MAP_OFS = 12'h080;
    localparam logic [4:0] MAP_SEL = 5'h01;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_NRES_BIT = 0;
    localparam int ENT_RES_BIT = 8;
    localparam int ENT_ACC_BIT = 9;
    localparam int ENT_WR_BIT = 10;
    localparam int FLT_SPACE_LO = 16;
    localparam int FLT_WR_BIT = 18;

    // values after reset
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic STAT_RST = 1'b0;
    localparam logic MASK_RST = 1'b0;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {PAT_IDLE, PAT_LOOK, PAT_ISSUE} pat_state_e;
endpackage

// ---- hdl/pat_map_ram.sv ----
// page map store: one write port, two registered read ports
// assumes one clock; read data appear one edge after the address
`timescale 1ns/10ps
`default_nettype none
module pat_map_ram #(
    parameter int AW = 5,
    parameter int DW = 6
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic [AW-1:0] rda_addr_in,
    output logic [DW-1:0] rda_data_out,
    input wire logic [AW-1:0] rdb_addr_in,
    output logic [DW-1:0] rdb_data_out
);
    logic [DW-1:0] mem_ff [0:(1<<AW)-1];

    ////////////////////////////////////////////////////////////////////////////
    // no reset on contents: software loads every entry before enabling
    always_ff @(posedge clk_in)
    begin
        if (wr_en_in)
        begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
        rda_data_out <= mem_ff[rda_addr_in];
        rdb_data_out <= mem_ff[rdb_addr_in];
    end
endmodule
`default_nettype wire

// ---- hdl/pat_usage.sv ----
// per-page accessed and written flags
// assumes set and clear come from the same clock; set wins over clear
`timescale 1ns/10ps
`default_nettype none
module pat_usage #(
    parameter int AW = 5
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic set_in,
    input wire logic set_wr_in,
    input wire logic [AW-1:0] set_idx_in,
    input wire logic clr_in,
    input wire logic [AW-1:0] clr_idx_in,
    output logic [(1<<AW)-1:0] acc_out,
    output logic [(1<<AW)-1:0] wr_out
);
    localparam int N = 1 << AW;
    logic [N-1:0] nxt_acc;
    logic [N-1:0] nxt_wr;

    ////////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < N; i++)
    begin : g_page
        always_comb
        begin
            nxt_acc[i] = acc_out[i];
            nxt_wr[i] = wr_out[i];
            if (clr_in && clr_idx_in == AW'(i))
            begin
                nxt_acc[i] = 1'b0;
                nxt_wr[i] = 1'b0;
            end
            if (set_in && set_idx_in == AW'(i))
            begin
                nxt_acc[i] = 1'b1;
                if (set_wr_in)
                begin
                    nxt_wr[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            acc_out <= '0;
            wr_out <= '0;
        end
        else
        begin
            acc_out <= nxt_acc;
            wr_out <= nxt_wr;
        end
    end
endmodule
`default_nettype wire

// ---- sim/pat_checker.sv ----
// assertions on the translation unit's bus, core and memory ports
// assumes it is bound to pat_translate by the statement at the foot
`timescale 1ns/10ps
`default_nettype none
module pat_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic req_valid_in,
    input wire logic [15:0] req_addr_in,
    input wire logic req_ready_out,
    input wire logic req_done_out,
    input wire logic req_abort_out,
    input wire logic mem_valid_out,
    input wire logic mem_write_out,
    input wire logic [17:0] mem_addr_out,
    input wire logic mem_ready_in
);
    logic [15:0] va_ff;
    logic [15:0] nxt_va;
    always_comb nxt_va = (req_valid_in && req_ready_out) ? req_addr_in : va_ff;
    always_ff @(posedge clk_in) va_ff <= nxt_va;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////
    chk_apb_wait: assert property ((psel_in && !penable_in) ##1
        (psel_in && penable_in) |=> pready_out)
        else $error("apb answer not after one wait state");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    chk_take_busy: assert property (req_valid_in && req_ready_out |=> !req_ready_out)
        else $error("core ready stays high after a take");
    chk_take_answer: assert property (req_valid_in && req_ready_out |-> ##2
        (mem_valid_out || req_abort_out))
        else $error("no memory request or abort two cycles after a take");
    chk_mem_hold: assert property (mem_valid_out && !mem_ready_in |=>
        mem_valid_out && $stable(mem_addr_out) && $stable(mem_write_out))
        else $error("memory request changed before accepted");
    chk_done_after: assert property (mem_valid_out && mem_ready_in |=>
        req_done_out && !mem_valid_out ##1 !req_done_out)
        else $error("done not a single pulse after memory accept");
    chk_abort_nomem: assert property (req_abort_out |->
        !mem_valid_out && !req_done_out ##1 !req_abort_out)
        else $error("abort with memory cycle or longer than a pulse");
    chk_page_offset: assert property (mem_valid_out |->
        mem_addr_out[12:0] == va_ff[12:0])
        else $error("page offset not carried to physical address");
    cover property (req_abort_out);
    cover property (mem_valid_out && mem_write_out && mem_ready_in);
    cover property (pslverr_out);
endmodule
bind pat_translate pat_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .req_valid_in(req_valid_in), .req_addr_in(req_addr_in), .req_ready_out(req_ready_out),
    .req_done_out(req_done_out), .req_abort_out(req_abort_out), .mem_valid_out(mem_valid_out),
    .mem_write_out(mem_write_out), .mem_addr_out(mem_addr_out), .mem_ready_in(mem_ready_in));
`default_nettype wire

// ---- sim/pat_core_model.sv ----
// core model: presents virtual transfers with the status word, waits for done or abort
// assumes one clock shared with the unit; lines change only just after rising edges
`timescale 1ns/10ps
`default_nettype none
module pat_core_model (
    input wire logic clk_in,
    input wire logic ready_in,
    input wire logic done_in,
    input wire logic abort_in,
    output logic valid_out = 1'b0,
    output logic write_out = 1'b0,
    output logic [15:0] addr_out = 16'h0000,
    output logic [15:0] psw_out = 16'h0000
);
    // released lines are inverted so a stale address never passes for a held one
    task automatic xfer(input logic wr, input logic [15:0] va, input logic [15:0] psw,
        output logic aborted, output logic timed_out);
        int n;
        @(posedge clk_in);
        valid_out <= 1'b1;
        write_out <= wr;
        addr_out <= va;
        psw_out <= psw;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (ready_in !== 1'b1 && n < 50);
        valid_out <= 1'b0;
        write_out <= ~wr;
        addr_out <= ~va;
        psw_out <= ~psw;
        while (done_in !== 1'b1 && abort_in !== 1'b1 && n < 100)
        begin
            @(posedge clk_in);
            n++;
        end
        aborted = abort_in;
        timed_out = n >= 100;
    endtask
endmodule
`default_nettype wire

// ---- sim/pat_tb.sv ----
// testbench: loads the page map over apb and runs core transfers to a simple memory
// assumes pat_core_model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, rdy, done, abort, mv, mw, irq, rv, rw, er, ab, to;
    logic [15:0] ra, psw;
    logic [17:0] ma, pa;
    logic pw, mem_ready = 1'b1, slow = 1'b0;
    logic [1:0] cyc = 2'h0;
    int nmem = 0, n0, errors = 0, samples_checked = 0;
    always #10 clk_in = ~clk_in;
    // slow memory accepts one cycle in four
    always @(posedge clk_in)
    begin
        cyc <= cyc + 2'h1;
        mem_ready <= !slow || cyc == 2'h0;
        if (mv === 1'b1 && mem_ready === 1'b1)
        begin
            pa <= ma;
            pw <= mw;
            nmem <= nmem + 1;
        end
    end
    pat_translate DUT (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .req_valid_in(rv), .req_write_in(rw),
        .req_addr_in(ra), .processor_status_word_in(psw), .req_ready_out(rdy),
        .req_done_out(done), .req_abort_out(abort), .mem_valid_out(mv),
        .mem_write_out(mw), .mem_addr_out(ma), .mem_ready_in(mem_ready), .irq_out(irq));
    pat_core_model core (.clk_in(clk_in), .ready_in(rdy), .done_in(done), .abort_in(abort),
        .valid_out(rv), .write_out(rw), .addr_out(ra), .psw_out(psw));
    ////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            errors++;
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic go(input logic w, input logic [15:0] va, input logic [15:0] s,
        input logic [17:0] e);
        int k;
        k = nmem;
        core.xfer(w, va, s, ab, to);
        if (to !== 1'b0)
            errors++;
        `CHK(ab, 1'b0)
        `CHK(nmem, k + 1)
        `CHK(pa, e)
        `CHK(pw, w)
    endtask
    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_in);
        errors++;
        summarize();
    end
    initial
    begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(pat_pkg::CTRL_OFS, 32'h0);
        rd(pat_pkg::STATUS_OFS, 32'h0);
        rd(pat_pkg::MASK_OFS, 32'h0);
        rd(12'h040, 32'h0);
        `CHK(er, 1'b1)
        go(1'b0, 16'h1234, 16'h0000, 18'h01234);
        $display("test reset_identity done");
        // frame is 31 minus index; entries 5 and 13 are not resident
        for (int i = 0; i < 32; i++)
            apb(1'b1, pat_pkg::MAP_OFS + 12'(4 * i),
                {23'h0, i != 5 && i != 13, 3'h0, 5'(31 - i)});
        rd(pat_pkg::MAP_OFS + 12'h024, 32'h0000_0116);
        apb(1'b1, pat_pkg::MASK_OFS, 32'h1);
        apb(1'b1, pat_pkg::CTRL_OFS, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            slow <= m == 3;
            go(m[0], 16'h5abc, {m[1:0], 14'h0}, {5'(29 - 8 * m), 13'h1abc});
            rd(pat_pkg::MAP_OFS + 12'(32 * m + 8),
                {21'h0, m[0], 2'h3, 3'h0, 5'(29 - 8 * m)});
        end
        slow <= 1'b0;
        $display("test map_select done");
        n0 = nmem;
        core.xfer(1'b1, 16'ha123, 16'h0000, ab, to);
        `CHK(ab, 1'b1)
        `CHK(nmem, n0)
        rd(pat_pkg::FAULT_OFS, 32'h0004_a123);
        rd(pat_pkg::STATUS_OFS, 32'h1);
        `CHK(irq, 1'b1)
        rd(pat_pkg::MAP_OFS + 12'h014, 32'h0000_001a);
        apb(1'b1, pat_pkg::MASK_OFS, 32'h0);
        rd(pat_pkg::MASK_OFS, 32'h0);
        `CHK(irq, 1'b0)
        apb(1'b1, pat_pkg::MASK_OFS, 32'h1);
        apb(1'b1, pat_pkg::STATUS_OFS, 32'h1);
        rd(pat_pkg::STATUS_OFS, 32'h0);
        `CHK(irq, 1'b0)
        $display("test fault_trap done");
        apb(1'b1, pat_pkg::MAP_OFS + 12'h008, 32'h0000_0103);
        rd(pat_pkg::MAP_OFS + 12'h008, 32'h0000_0103);
        // entry 10 was written through in map 1, so its written flag must clear too
        apb(1'b1, pat_pkg::MAP_OFS + 12'h028, 32'h0000_0115);
        rd(pat_pkg::MAP_OFS + 12'h028, 32'h0000_0115);
        go(1'b1, 16'h4001, 16'h0000, 18'h06001);
        go(1'b0, 16'h0000, 16'h0000, 18'h3e000);
        $display("test reload done");
        summarize();
    end
endmodule
`default_nettype wire
